// [inc/lbt_pkg.sv]
package lbt_pkg;

    // ****************************************************************
    // Frame identifiers and command codes
    // ****************************************************************
    localparam logic [10:0] ID_REQUEST = 11'h7E5;
    localparam logic [10:0] ID_REPLY = 11'h7E4;
    localparam logic [7:0] CS_SWITCH_GLOBAL = 8'h04;
    localparam logic [7:0] MODE_CONFIG = 8'h01;
    localparam logic [7:0] MODE_WAITING = 8'h00;
    localparam logic [7:0] CS_CONFIG_TIMING = 8'h13;
    localparam logic [7:0] CS_ACTIVATE_TIMING = 8'h15;
    localparam logic [7:0] CS_STORE = 8'h17;
    localparam logic [7:0] TABLE_STANDARD = 8'h00;
    localparam logic [7:0] REPLY_OK = 8'h00;
    localparam logic [3:0] LEN_SWITCH = 4'h2;
    localparam logic [3:0] LEN_TIMING = 4'h3;
    localparam logic [3:0] LEN_STORE = 4'h1;
    localparam logic [3:0] LEN_REPLY = 4'h3;

    // ****************************************************************
    // Bit rate indexes and defaults
    // ****************************************************************
    localparam logic [3:0] RATE_1M = 4'h0;
    localparam logic [3:0] RATE_800K = 4'h1;
    localparam logic [3:0] RATE_500K = 4'h2;
    localparam logic [3:0] RATE_250K = 4'h3;
    localparam logic [3:0] RATE_125K = 4'h4;
    localparam logic [3:0] RATE_RSVD = 4'h5;
    localparam logic [3:0] RATE_50K = 4'h6;
    localparam logic [3:0] RATE_20K = 4'h7;
    localparam logic [3:0] RATE_10K = 4'h8;
    localparam logic [3:0] RATE_DEFAULT = RATE_125K;
    localparam logic [6:0] NODE_ID_DEFAULT = 7'h7F;

    // ****************************************************************
    // Timing: delay unit of 1 ms at a 125 MHz clock
    // ****************************************************************
    localparam int CLK_MHZ = 125;
    localparam int DELAY_UNIT_US = 1000;
    localparam int UNIT_CYCLES = DELAY_UNIT_US * CLK_MHZ;

    // ****************************************************************
    // Frame carrier
    // ****************************************************************
    typedef struct packed {
        logic [10:0] id;
        logic [3:0] len;
        logic [7:0] d0;
        logic [7:0] d1;
        logic [7:0] d2;
    } lbt_frame_s;

    typedef enum logic [5:0] {
        ST_WAITING = 6'b000001,
        ST_CONFIG = 6'b000010,
        ST_DELAY1 = 6'b000100,
        ST_DELAY2 = 6'b001000,
        ST_STORING = 6'b010000,
        ST_REPLY = 6'b100000
    } lbt_state_e;

endpackage

// [src/lbt_bit_timing_config.sv]
// How it works
// - Commands on 0x7E5, replies on 0x7E4.
// - Switch 0x04,0x01 enters configuration state.
// - Command 0x13, table 0x00, index latched pending.
// - Index decodes to rates, index 5 reserved.
// - Timing request answered 0x13,0x00,0x00.
// - Activate 0x15 with delay low then high.
// - Wait delay, switch rate, wait delay again.
// - Store to non-volatile memory, reply 0x17,0,0.
// - Switch 0x04,0x00 enters waiting state and resets module in the same cycle.
// - Default node 127 and 125 kbit/s.
module lbt_bit_timing_config #(
    parameter int UNIT_CYCLES = lbt_pkg::UNIT_CYCLES
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic rx_valid,
    input wire lbt_pkg::lbt_frame_s rx_frame,
    output logic tx_valid,
    input wire logic tx_ready,
    output lbt_pkg::lbt_frame_s tx_frame,
    input wire logic [3:0] stored_rate,
    input wire logic stored_valid,
    output logic store_req,
    input wire logic store_done,
    output logic [3:0] active_rate,
    output logic [3:0] pending_rate,
    output logic rate_supported,
    output logic tx_hold,
    output logic [6:0] node_id,
    output logic module_reset
);

    // ****************************************************************
    // Request decode
    // ****************************************************************
    logic for_us;
    logic is_switch;
    logic is_cfg;
    logic is_act;
    logic is_store;

    // Only frames on the request identifier are looked at.
    assign for_us = rx_valid && rx_frame.id == lbt_pkg::ID_REQUEST;
    assign is_switch = for_us && rx_frame.len == lbt_pkg::LEN_SWITCH
        && rx_frame.d0 == lbt_pkg::CS_SWITCH_GLOBAL;
    assign is_cfg = for_us && rx_frame.len == lbt_pkg::LEN_TIMING
        && rx_frame.d0 == lbt_pkg::CS_CONFIG_TIMING
        && rx_frame.d1 == lbt_pkg::TABLE_STANDARD;
    assign is_act = for_us && rx_frame.len == lbt_pkg::LEN_TIMING
        && rx_frame.d0 == lbt_pkg::CS_ACTIVATE_TIMING;
    assign is_store = for_us && rx_frame.len == lbt_pkg::LEN_STORE
        && rx_frame.d0 == lbt_pkg::CS_STORE;

    // Reserved and out-of-table indexes are not supported rates.
    function automatic logic rate_ok(input logic [7:0] idx);
        rate_ok = idx <= 8'(lbt_pkg::RATE_10K)
            && idx != 8'(lbt_pkg::RATE_RSVD);
    endfunction

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    lbt_pkg::lbt_state_e state, next_state;
    logic [15:0] delay_ms, next_delay_ms;
    logic [15:0] ms_left, next_ms_left;
    logic [31:0] tick, next_tick;
    logic [3:0] next_active_rate;
    logic [3:0] next_pending_rate;
    logic next_tx_valid;
    lbt_pkg::lbt_frame_s next_tx_frame;
    logic next_store_req;
    logic next_module_reset;
    logic boot, next_boot;

    // Timing and store requests are taken only in configuration state,
    // and a reply must drain before the next timing or store command is looked at; activate and switch are not held back.
    always_comb begin
        next_state = state;
        next_delay_ms = delay_ms;
        next_ms_left = ms_left;
        next_tick = tick;
        next_active_rate = active_rate;
        next_pending_rate = pending_rate;
        next_tx_valid = tx_valid && !tx_ready;
        next_tx_frame = tx_frame;
        next_store_req = 1'b0;
        next_module_reset = 1'b0;
        next_boot = 1'b0;
        // Stored rate is picked up once after reset; default otherwise.
        if (boot && stored_valid && rate_ok(8'(stored_rate))) begin
            next_active_rate = stored_rate;
            next_pending_rate = stored_rate;
        end
        case (state)
            lbt_pkg::ST_WAITING: begin
                if (is_switch && rx_frame.d1 == lbt_pkg::MODE_CONFIG) begin
                    next_state = lbt_pkg::ST_CONFIG;
                end
            end
            lbt_pkg::ST_CONFIG: begin
                if (is_switch && rx_frame.d1 == lbt_pkg::MODE_WAITING) begin
                    next_state = lbt_pkg::ST_WAITING;
                    next_module_reset = 1'b1;
                end else if (is_cfg && !tx_valid) begin
                    if (rate_ok(rx_frame.d2)) begin
                        next_pending_rate = rx_frame.d2[3:0];
                    end
                    next_tx_valid = 1'b1;
                    next_tx_frame = '{lbt_pkg::ID_REPLY, lbt_pkg::LEN_REPLY,
                        lbt_pkg::CS_CONFIG_TIMING, lbt_pkg::REPLY_OK,
                        lbt_pkg::REPLY_OK};
                end else if (is_act) begin
                    next_delay_ms = {rx_frame.d2, rx_frame.d1};
                    next_ms_left = {rx_frame.d2, rx_frame.d1};
                    next_tick = 32'(UNIT_CYCLES - 1);
                    next_state = lbt_pkg::ST_DELAY1;
                end else if (is_store && !tx_valid) begin
                    next_store_req = 1'b1;
                    next_state = lbt_pkg::ST_STORING;
                end
            end
            lbt_pkg::ST_DELAY1, lbt_pkg::ST_DELAY2: begin
                // Each period counts whole milliseconds of clock ticks.
                if (ms_left == 16'h0000) begin
                    if (state == lbt_pkg::ST_DELAY1) begin
                        next_active_rate = pending_rate;
                        next_ms_left = delay_ms;
                        next_tick = 32'(UNIT_CYCLES - 1);
                        next_state = lbt_pkg::ST_DELAY2;
                    end else begin
                        next_state = lbt_pkg::ST_CONFIG;
                    end
                end else if (tick == 32'h0) begin
                    next_tick = 32'(UNIT_CYCLES - 1);
                    next_ms_left = ms_left - 16'h0001;
                end else begin
                    next_tick = tick - 32'h1;
                end
            end
            lbt_pkg::ST_STORING: begin
                if (store_done) begin
                    next_tx_valid = 1'b1;
                    next_tx_frame = '{lbt_pkg::ID_REPLY, lbt_pkg::LEN_REPLY,
                        lbt_pkg::CS_STORE, lbt_pkg::REPLY_OK,
                        lbt_pkg::REPLY_OK};
                    next_state = lbt_pkg::ST_CONFIG;
                end
            end
            default: begin
                next_state = lbt_pkg::ST_WAITING;
            end
        endcase
    end

    // Registers of the sequencer; defaults give node 127 at 125 kbit/s.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state <= lbt_pkg::ST_WAITING;
            delay_ms <= 16'h0000;
            ms_left <= 16'h0000;
            tick <= 32'h0;
            active_rate <= lbt_pkg::RATE_DEFAULT;
            pending_rate <= lbt_pkg::RATE_DEFAULT;
            tx_valid <= 1'b0;
            tx_frame <= '0;
            store_req <= 1'b0;
            module_reset <= 1'b0;
            boot <= 1'b1;
        end else begin
            state <= next_state;
            delay_ms <= next_delay_ms;
            ms_left <= next_ms_left;
            tick <= next_tick;
            active_rate <= next_active_rate;
            pending_rate <= next_pending_rate;
            tx_valid <= next_tx_valid;
            tx_frame <= next_tx_frame;
            store_req <= next_store_req;
            module_reset <= next_module_reset;
            boot <= next_boot;
        end
    end

    // Node identity is not changed by this block.
    assign node_id = lbt_pkg::NODE_ID_DEFAULT;
    assign rate_supported = rate_ok(8'(active_rate));
    // No frames at the new rate until the second period ends.
    assign tx_hold = state == lbt_pkg::ST_DELAY1
        || state == lbt_pkg::ST_DELAY2;

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_act_req;
        state == lbt_pkg::ST_CONFIG && is_act;
    endsequence
    sequence s_switch_done;
        state == lbt_pkg::ST_DELAY2;
    endsequence

    property p_reply_id;
        @(posedge clock) disable iff (!arst_n)
        tx_valid |-> tx_frame.id == lbt_pkg::ID_REPLY;
    endproperty
    a_reply_id: assert property (p_reply_id)
        else $error("reply not on reply identifier");

    property p_enter_cfg;
        @(posedge clock) disable iff (!arst_n)
        state == lbt_pkg::ST_WAITING && is_switch
            && rx_frame.d1 == lbt_pkg::MODE_CONFIG
            |=> state == lbt_pkg::ST_CONFIG;
    endproperty
    a_enter_cfg: assert property (p_enter_cfg)
        else $error("switch to configuration not taken");

    property p_cfg_reply;
        @(posedge clock) disable iff (!arst_n)
        state == lbt_pkg::ST_CONFIG && is_cfg && !tx_valid
            |=> tx_valid && tx_frame.d0 == lbt_pkg::CS_CONFIG_TIMING
            && tx_frame.d1 == 8'h00 && tx_frame.d2 == 8'h00;
    endproperty
    a_cfg_reply: assert property (p_cfg_reply)
        else $error("bad timing reply");

    property p_latch;
        @(posedge clock) disable iff (!arst_n)
        state == lbt_pkg::ST_CONFIG && is_cfg && !tx_valid
            && rate_ok(rx_frame.d2) |=> pending_rate == $past(rx_frame.d2[3:0]);
    endproperty
    a_latch: assert property (p_latch)
        else $error("rate index not latched");

    property p_no_reserved;
        @(posedge clock) disable iff (!arst_n)
        pending_rate != lbt_pkg::RATE_RSVD && pending_rate <= lbt_pkg::RATE_10K;
    endproperty
    a_no_reserved: assert property (p_no_reserved)
        else $error("unsupported rate pending");

    property p_activate;
        @(posedge clock) disable iff (!arst_n)
        s_act_req |=> tx_hold && active_rate == $past(active_rate);
    endproperty
    a_activate: assert property (p_activate)
        else $error("rate switched without delay");

    property p_switch_rate;
        @(posedge clock) disable iff (!arst_n)
        $rose(state == lbt_pkg::ST_DELAY2) |-> s_switch_done
            ##0 active_rate == pending_rate;
    endproperty
    a_switch_rate: assert property (p_switch_rate)
        else $error("new rate not applied after first period");

    property p_store;
        @(posedge clock) disable iff (!arst_n)
        state == lbt_pkg::ST_STORING && store_done
            |=> tx_valid && tx_frame.d0 == lbt_pkg::CS_STORE;
    endproperty
    a_store: assert property (p_store)
        else $error("store not answered");

    property p_ignore;
        @(posedge clock) disable iff (!arst_n)
        state == lbt_pkg::ST_WAITING && !tx_valid |=> !tx_valid && !store_req;
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("command acted on outside configuration");

    property p_leave;
        @(posedge clock) disable iff (!arst_n)
        state == lbt_pkg::ST_CONFIG && is_switch
            && rx_frame.d1 == lbt_pkg::MODE_WAITING
            |=> module_reset && state == lbt_pkg::ST_WAITING;
    endproperty
    a_leave: assert property (p_leave)
        else $error("switch to waiting did not reset");

endmodule // lbt_bit_timing_config

// [verification/lbt_cfg_partner.sv]
// ****************************************************************
// Far side: reply acceptor and non-volatile store
// ****************************************************************
module lbt_cfg_partner (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic slow,
    input wire logic store_req,
    output logic store_done,
    output logic tx_ready
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] tick;
    logic [2:0] wait_cnt;

    // In slow mode the controller takes a reply only every fourth cycle.
    assign tx_ready = !slow || (tick[1:0] == 2'h0);

    // The store write takes one cycle, or seven when slow; one pulse ends it.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tick <= 3'h0;
            wait_cnt <= 3'h0;
            store_done <= 1'b0;
        end else begin
            tick <= tick + 3'h1;
            store_done <= (wait_cnt == 3'h1);
            if (store_req) begin
                wait_cnt <= slow ? 3'h7 : 3'h1;
            end else if (wait_cnt != 3'h0) begin
                wait_cnt <= wait_cnt - 3'h1;
            end
        end
    end
endmodule // lbt_cfg_partner

// [verification/lbt_bit_timing_config_tb.sv]
module lbt_bit_timing_config_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int UC = 4;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic rx_valid = 1'b0;
    lbt_pkg::lbt_frame_s rx_frame = '0;
    logic slow = 1'b0;
    logic [3:0] stored_rate = 4'h0;
    logic stored_valid = 1'b0;
    logic tx_valid, tx_ready, store_req, store_done;
    lbt_pkg::lbt_frame_s tx_frame;
    logic [3:0] active_rate, pending_rate;
    logic rate_supported, tx_hold, module_reset;
    logic [6:0] node_id;
    int errors = 0;
    int n_tests = 0;

    // Free-running 125 MHz clock.
    always #4 clock = ~clock;

    lbt_bit_timing_config #(.UNIT_CYCLES(UC)) i_dut (
        .clock(clock), .arst_n(arst_n), .rx_valid(rx_valid),
        .rx_frame(rx_frame), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_frame(tx_frame), .stored_rate(stored_rate),
        .stored_valid(stored_valid), .store_req(store_req),
        .store_done(store_done), .active_rate(active_rate),
        .pending_rate(pending_rate), .rate_supported(rate_supported),
        .tx_hold(tx_hold), .node_id(node_id), .module_reset(module_reset)
    );
    lbt_cfg_partner i_partner (
        .clock(clock), .arst_n(arst_n), .slow(slow), .store_req(store_req),
        .store_done(store_done), .tx_ready(tx_ready)
    );

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    // Wide enough for a whole frame, so no part of it is dropped.
    task automatic check(input logic [38:0] seen, input logic [38:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // The frame is inverted after use so a stale value never looks valid.
    task automatic send(input logic [10:0] id, input logic [3:0] len,
                        input logic [7:0] a, b, c);
        @(negedge clock);
        rx_valid = 1'b1;
        rx_frame = '{id, len, a, b, c};
        @(negedge clock);
        rx_valid = 1'b0;
        rx_frame = ~rx_frame;
    endtask

    // The drain is bounded separately so a stuck reply cannot hang here.
    task automatic reply(input logic [7:0] cs, output int n);
        int k;
        n = 0;
        k = 0;
        while (tx_valid !== 1'b1 && n < 50) begin
            @(negedge clock);
            n++;
        end
        check(tx_frame.id, lbt_pkg::ID_REPLY);
        check(tx_frame, {lbt_pkg::ID_REPLY, lbt_pkg::LEN_REPLY, cs,
              lbt_pkg::REPLY_OK, lbt_pkg::REPLY_OK});
        while (tx_valid === 1'b1 && k < 60) begin
            @(negedge clock);
            k++;
        end
    endtask

    task automatic quiet();
        logic seen;
        seen = 1'b0;
        repeat (10) begin
            @(negedge clock);
            seen = seen | (tx_valid !== 1'b0);
        end
        check(seen, 1'b0);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_defaults();
        check({active_rate, pending_rate, node_id}, {8'h44, 7'h7F});
        check(rate_supported, 1'b1);
    endtask

    task automatic t_refused();
        send(11'h7E4, 4'h2, 8'h04, 8'h01, 8'h00);
        send(11'h7E5, 4'h3, 8'h13, 8'h00, 8'h02);
        quiet();
        check(pending_rate, 4'h4);
    endtask

    task automatic t_config();
        int n;
        logic [3:0] exp;
        exp = 4'h4;
        send(11'h7E5, 4'h2, 8'h04, 8'h01, 8'h00);
        for (int i = 0; i <= 8; i++) begin
            send(11'h7E5, 4'h3, 8'h13, 8'h00, 8'(i));
            if (i != 5) exp = 4'(i);
            reply(8'h13, n);
            check(n, 0);
            check(pending_rate, exp);
        end
        send(11'h7E5, 4'h3, 8'h13, 8'h01, 8'h03);
        quiet();
        check(pending_rate, 4'h8);
    endtask

    // Delay is sent low byte first; both periods are measured.
    task automatic t_act(input logic [7:0] lo, hi, input logic [3:0] rate);
        int d, n, sw;
        d = {hi, lo};
        sw = -1;
        // Make the wanted rate pending first, so the switch is visible.
        send(11'h7E5, 4'h3, 8'h13, 8'h00, 8'(rate));
        reply(8'h13, n);
        n = 0;
        send(11'h7E5, 4'h3, 8'h15, lo, hi);
        @(negedge clock);
        while (tx_hold === 1'b1 && n < 3000) begin
            if (sw < 0 && active_rate === rate) sw = n;
            @(negedge clock);
            n++;
        end
        check(sw >= d * UC && sw <= d * UC + 4, 1'b1);
        check(n >= 2 * d * UC && n <= 2 * d * UC + 6, 1'b1);
        check(active_rate, rate);
    endtask

    task automatic t_store();
        int n, p;
        p = 0;
        slow = 1'b1;
        send(11'h7E5, 4'h1, 8'h17, 8'h00, 8'h00);
        repeat (3) begin
            if (store_req === 1'b1) p++;
            @(negedge clock);
        end
        check(p, 1);
        reply(8'h17, n);
        slow = 1'b0;
    endtask

    task automatic t_leave();
        int p;
        p = 0;
        send(11'h7E5, 4'h2, 8'h04, 8'h00, 8'h00);
        repeat (3) begin
            if (module_reset === 1'b1) p++;
            @(negedge clock);
        end
        check(p, 1);
        send(11'h7E5, 4'h3, 8'h13, 8'h00, 8'h02);
        quiet();
    endtask

    task automatic t_boot();
        @(negedge clock);
        arst_n = 1'b0;
        stored_valid = 1'b1;
        stored_rate = 4'h3;
        repeat (4) @(negedge clock);
        arst_n = 1'b1;
        repeat (2) @(negedge clock);
        check(active_rate, 4'h3);
    endtask

    // ****************************************************************
    // Sequence, watchdog and verdict
    // ****************************************************************
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Main sequence after four cycles of reset.
    initial begin
        repeat (4) @(negedge clock);
        arst_n = 1'b1;
        repeat (2) @(negedge clock);
        t_defaults();
        t_refused();
        t_config();
        t_act(8'h02, 8'h00, 4'h8);
        t_act(8'h00, 8'h01, 4'h3);
        t_store();
        t_leave();
        t_boot();
        conclude();
    end

    // The run needs well under 5000 cycles; this cuts off a hang.
    initial begin
        #100us;
        errors++;
        conclude();
    end
endmodule // lbt_bit_timing_config_tb
